// ---- fan_regs_pkg.sv ----
package fan_regs_pkg;

    // ------------------------------------------------------------------
    // Command codes selecting each register
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_FAN_SPEED_READING    = 8'h00;
    localparam logic [7:0] CMD_SPEED_ALARM_THRESHOLD = 8'h02;
    localparam logic [7:0] CMD_CONTROL_SETTINGS     = 8'h04;
    localparam logic [7:0] CMD_CONDITION_FLAGS      = 8'h05;
    localparam logic [7:0] CMD_DRIVE_LEVEL_SETTING  = 8'h06;
    localparam logic [7:0] CMD_MAKER_CODE           = 8'h07;
    localparam logic [7:0] CMD_REVISION_CODE        = 8'h08;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [8:0] RST_FAN_SPEED_READING    = 9'h000;
    localparam logic [7:0] RST_SPEED_ALARM_THRESHOLD = 8'h0a;
    localparam logic [7:0] RST_CONTROL_SETTINGS     = 8'h0a;
    localparam logic [7:0] RST_DRIVE_LEVEL_SETTING  = 8'h02;
    localparam logic [7:0] RST_READ_DATA            = 8'h00;

    // ------------------------------------------------------------------
    // Field positions of control_settings
    // ------------------------------------------------------------------
    localparam int CFG_FAULT_CLEAR_BIT      = 7;
    localparam int CFG_RESOLUTION_BIT       = 6;
    localparam int CFG_DRIVE_SOURCE_BIT     = 5;
    localparam int CFG_FIXED_ZERO_BIT       = 4;
    localparam int CFG_FIXED_ONE_BIT        = 3;
    localparam int CFG_PPR_HI_BIT           = 2;
    localparam int CFG_PPR_LO_BIT           = 1;
    localparam int CFG_SHUTDOWN_BIT         = 0;

    // ------------------------------------------------------------------
    // Field positions of condition_flags
    // ------------------------------------------------------------------
    localparam int STS_FAN_FAULT_BIT        = 0;
    localparam int STS_INPUT_OPEN_BIT       = 2;
    localparam int STS_OVERFLOW_BIT         = 3;
    localparam int STS_OVERTEMP_BIT         = 5;

    // ------------------------------------------------------------------
    // Timing: one measurement window, also the fault persistence time
    // ------------------------------------------------------------------
    localparam longint CORE_CLK_KHZ         = 250000;
    localparam longint MEAS_WINDOW_MS       = 2400;
    localparam longint FAULT_DELAY_MS       = 2400;
    localparam longint MEAS_WINDOW_CYCLES   = MEAS_WINDOW_MS * CORE_CLK_KHZ;
    localparam longint FAULT_DELAY_CYCLES   = FAULT_DELAY_MS * CORE_CLK_KHZ;

    // Largest reading in 25 FAN_SPEED_READING units (12775 FAN_SPEED_READING)
    localparam logic [8:0] SPEED_MAX_UNITS  = 9'h1ff;

endpackage

// ---- fan_controller_register_set.sv ----
`timescale 1ns/1ps
module fan_controller_register_set
    import fan_regs_pkg::*;
#(
    parameter longint     MEAS_CYCLES  = MEAS_WINDOW_CYCLES,
    parameter longint     FAULT_CYCLES = FAULT_DELAY_CYCLES,
    parameter logic [7:0] MAKER_VALUE  = 8'h5a,   // Arbitrary value
    parameter logic [1:0] VARIANT      = 2'b01    // Arbitrary value
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_clk_en,
    input  wire logic       i_cmd_wr,
    input  wire logic [7:0] i_cmd,
    input  wire logic       i_data_wr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_rd_req,
    input  wire logic       i_tach_pin,
    input  wire logic       i_overtemp_pin,
    input  wire logic       i_input_open_pin,
    input  wire logic [7:0] i_analog_duty,
    output logic      [7:0] o_rd_data,
    output logic            o_rd_valid,
    output logic            o_alarm_n,
    output logic      [7:0] o_drive_level,
    output logic            o_shutdown
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (MEAS_CYCLES < 1 || MEAS_CYCLES > 64'hffff_ffff) begin : g_bad_meas
        $error("MEAS_CYCLES must fit 1 to 2**32-1");
    end
    if (FAULT_CYCLES < 1 || FAULT_CYCLES > 64'hffff_ffff) begin : g_bad_fault
        $error("FAULT_CYCLES must fit 1 to 2**32-1");
    end

    localparam logic [31:0] MEAS_LAST  = 32'(MEAS_CYCLES - 1);
    localparam logic [31:0] FAULT_LAST = 32'(FAULT_CYCLES - 1);

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    // Pulse count to 25 FAN_SPEED_READING units; window length makes one unit per rotation
    function automatic logic [12:0] pulses_to_units(input logic [12:0] pulses,
                                                    input logic [1:0]  ppr);
        pulses_to_units = pulses >> ppr;
    endfunction

    // Command code to register hit
    function automatic logic cmd_is(input logic [7:0] cmd, input logic [7:0] code);
        cmd_is = (cmd == code);
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] tach_sync_q;
    logic [2:0] tach_sync_d;
    logic [1:0] otemp_sync_q;
    logic [1:0] otemp_sync_d;
    logic [1:0] open_sync_q;
    logic [1:0] open_sync_d;
    logic       tach_rise;

    // Third tach stage only serves edge detection
    always_comb begin
        tach_sync_d  = tach_sync_q;
        otemp_sync_d = otemp_sync_q;
        open_sync_d  = open_sync_q;
        if (i_clk_en) begin
            tach_sync_d  = {tach_sync_q[1:0], i_tach_pin};
            otemp_sync_d = {otemp_sync_q[0], i_overtemp_pin};
            open_sync_d  = {open_sync_q[0], i_input_open_pin};
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            tach_sync_q  <= 3'h0;
            otemp_sync_q <= 2'h0;
            open_sync_q  <= 2'h0;
        end else begin
            tach_sync_q  <= tach_sync_d;
            otemp_sync_q <= otemp_sync_d;
            open_sync_q  <= open_sync_d;
        end
    end

    assign tach_rise = tach_sync_q[1] & ~tach_sync_q[2];

    // ------------------------------------------------------------------
    // Host register port and writable registers
    // ------------------------------------------------------------------
    logic [7:0] cmd_ptr_q;
    logic [7:0] cmd_ptr_d;
    logic [7:0] threshold_q;
    logic [7:0] threshold_d;
    logic [7:0] config_q;
    logic [7:0] config_d;
    logic [7:0] drive_set_q;
    logic [7:0] drive_set_d;
    logic       fault_clear_req;

    // Pointer is kept so receive-byte reads reuse the last command
    always_comb begin
        cmd_ptr_d       = cmd_ptr_q;
        threshold_d     = threshold_q;
        config_d        = config_q;
        drive_set_d     = drive_set_q;
        fault_clear_req = 1'b0;
        if (i_clk_en && i_cmd_wr) begin
            cmd_ptr_d = i_cmd;
        end
        if (i_clk_en && i_data_wr) begin
            unique case (1'b1)
                cmd_is(cmd_ptr_q, CMD_SPEED_ALARM_THRESHOLD): threshold_d = i_wdata;
                cmd_is(cmd_ptr_q, CMD_CONTROL_SETTINGS): begin
                    config_d                      = i_wdata;
                    config_d[CFG_FAULT_CLEAR_BIT] = 1'b0;                 // Self-clearing command
                    config_d[CFG_FIXED_ZERO_BIT]  = 1'b0;
                    config_d[CFG_FIXED_ONE_BIT]   = 1'b1;
                    fault_clear_req = i_wdata[CFG_FAULT_CLEAR_BIT];
                end
                cmd_is(cmd_ptr_q, CMD_DRIVE_LEVEL_SETTING): drive_set_d = i_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cmd_ptr_q   <= CMD_FAN_SPEED_READING;
            threshold_q <= RST_SPEED_ALARM_THRESHOLD;
            config_q    <= RST_CONTROL_SETTINGS;
            drive_set_q <= RST_DRIVE_LEVEL_SETTING;
        end else begin
            cmd_ptr_q   <= cmd_ptr_d;
            threshold_q <= threshold_d;
            config_q    <= config_d;
            drive_set_q <= drive_set_d;
        end
    end

    // ------------------------------------------------------------------
    // Speed measurement
    // ------------------------------------------------------------------
    logic [31:0] win_cnt_q;
    logic [31:0] win_cnt_d;
    logic [12:0] pulse_cnt_q;
    logic [12:0] pulse_cnt_d;
    logic [8:0]  speed_q;
    logic [8:0]  speed_d;
    logic        overflow_q;
    logic        overflow_d;
    logic [12:0] units;
    logic        shut;

    assign shut  = config_q[CFG_SHUTDOWN_BIT];
    assign units = pulses_to_units(pulse_cnt_q, config_q[CFG_PPR_HI_BIT:CFG_PPR_LO_BIT]);

    // Window is frozen in shutdown; the last reading is held
    always_comb begin
        win_cnt_d   = win_cnt_q;
        pulse_cnt_d = pulse_cnt_q;
        speed_d     = speed_q;
        overflow_d  = overflow_q;
        if (i_clk_en && !shut) begin
            if (win_cnt_q == MEAS_LAST) begin
                win_cnt_d   = 32'h0;
                pulse_cnt_d = 13'h0;
                if (units > 13'(SPEED_MAX_UNITS)) begin
                    speed_d    = SPEED_MAX_UNITS;
                    overflow_d = 1'b1;
                end else begin
                    speed_d    = units[8:0];
                    overflow_d = 1'b0;
                end
            end else begin
                win_cnt_d = win_cnt_q + 32'h1;
                if (tach_rise && pulse_cnt_q != 13'h1fff) begin
                    pulse_cnt_d = pulse_cnt_q + 13'h1;
                end
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            win_cnt_q   <= 32'h0;
            pulse_cnt_q <= 13'h0;
            speed_q     <= RST_FAN_SPEED_READING;
            overflow_q  <= 1'b0;
        end else begin
            win_cnt_q   <= win_cnt_d;
            pulse_cnt_q <= pulse_cnt_d;
            speed_q     <= speed_d;
            overflow_q  <= overflow_d;
        end
    end

    // ------------------------------------------------------------------
    // Fan fault detection
    // ------------------------------------------------------------------
    logic [31:0] slow_cnt_q;
    logic [31:0] slow_cnt_d;
    logic        fault_q;
    logic        fault_d;
    logic        too_slow;

    // Threshold is in 50 FAN_SPEED_READING units, reading in 25 FAN_SPEED_READING units
    assign too_slow = speed_q < {threshold_q, 1'b0};

    // A new fault in the clearing cycle still wins over the clear
    always_comb begin
        slow_cnt_d = slow_cnt_q;
        fault_d    = fault_q;
        if (i_clk_en) begin
            if (fault_clear_req) begin
                fault_d    = 1'b0;
                slow_cnt_d = 32'h0;
            end
            if (!too_slow || shut) begin
                slow_cnt_d = 32'h0;
            end else if (slow_cnt_q == FAULT_LAST) begin
                fault_d    = 1'b1;
                slow_cnt_d = 32'h0;                                       // Rearm, else a later clear never wins
            end else if (!fault_clear_req) begin
                slow_cnt_d = slow_cnt_q + 32'h1;
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            slow_cnt_q <= 32'h0;
            fault_q    <= 1'b0;
        end else begin
            slow_cnt_q <= slow_cnt_d;
            fault_q    <= fault_d;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    logic [7:0] status;
    logic [7:0] speed_byte;
    logic [7:0] rd_data_d;
    logic       rd_valid_d;

    // Condition flags assembled live from state and synchronised pins
    always_comb begin
        status                     = 8'h00;
        status[STS_FAN_FAULT_BIT]  = fault_q;
        status[STS_INPUT_OPEN_BIT] = open_sync_q[1];
        status[STS_OVERFLOW_BIT]   = overflow_q;
        status[STS_OVERTEMP_BIT]   = otemp_sync_q[1];
    end

    // Fine mode saturates to all ones when the ninth bit is set
    always_comb begin
        if (config_q[CFG_RESOLUTION_BIT]) begin
            speed_byte = speed_q[8] ? 8'hff : speed_q[7:0];
        end else begin
            speed_byte = speed_q[8:1];
        end
    end

    // Unknown command codes read as zero
    always_comb begin
        rd_data_d  = o_rd_data;
        rd_valid_d = 1'b0;
        if (i_clk_en) begin
            rd_valid_d = i_rd_req;
            if (i_rd_req) begin
                unique case (1'b1)
                    cmd_is(cmd_ptr_q, CMD_FAN_SPEED_READING):     rd_data_d = speed_byte;
                    cmd_is(cmd_ptr_q, CMD_SPEED_ALARM_THRESHOLD): rd_data_d = threshold_q;
                    cmd_is(cmd_ptr_q, CMD_CONTROL_SETTINGS):      rd_data_d = config_q;
                    cmd_is(cmd_ptr_q, CMD_CONDITION_FLAGS):       rd_data_d = status;
                    cmd_is(cmd_ptr_q, CMD_DRIVE_LEVEL_SETTING):   rd_data_d = drive_set_q;
                    cmd_is(cmd_ptr_q, CMD_MAKER_CODE):            rd_data_d = MAKER_VALUE;
                    cmd_is(cmd_ptr_q, CMD_REVISION_CODE):         rd_data_d = {6'h00, VARIANT};
                    default:                                      rd_data_d = RST_READ_DATA;
                endcase
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rd_data  <= RST_READ_DATA;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_data  <= rd_data_d;
            o_rd_valid <= rd_valid_d;
        end
    end

    // ------------------------------------------------------------------
    // Drive level, alarm and shutdown outputs
    // ------------------------------------------------------------------
    logic [7:0] drive_d;
    logic       alarm_n_d;
    logic       shutdown_d;

    // Drive is forced off in shutdown to save fan power
    always_comb begin
        drive_d    = o_drive_level;
        alarm_n_d  = o_alarm_n;
        shutdown_d = o_shutdown;
        if (i_clk_en) begin
            alarm_n_d  = ~fault_d;
            shutdown_d = config_d[CFG_SHUTDOWN_BIT];
            if (config_q[CFG_SHUTDOWN_BIT]) begin
                drive_d = 8'h00;
            end else if (config_q[CFG_DRIVE_SOURCE_BIT]) begin
                drive_d = drive_set_q;
            end else begin
                drive_d = i_analog_duty;
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_drive_level <= 8'h00;
            o_alarm_n     <= 1'b1;
            o_shutdown    <= 1'b0;
        end else begin
            o_drive_level <= drive_d;
            o_alarm_n     <= alarm_n_d;
            o_shutdown    <= shutdown_d;
        end
    end

endmodule // fan_controller_register_set

// ---- fan_regs_properties.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Register set checker
// ----------------------------------------------------------------
module fan_regs_checker
    import fan_regs_pkg::*;
#(
    parameter longint     FAULT_CYCLES = 100,
    parameter logic [7:0] MAKER_VALUE  = 8'h5a,
    parameter logic [1:0] VARIANT      = 2'b01
) (
    input wire logic       i_core_clk,
    input wire logic       i_sys_rst,
    input wire logic       i_clk_en,
    input wire logic       i_cmd_wr,
    input wire logic [7:0] i_cmd,
    input wire logic       i_data_wr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_rd_req,
    input wire logic       i_tach_pin,
    input wire logic       i_overtemp_pin,
    input wire logic       i_input_open_pin,
    input wire logic [7:0] i_analog_duty,
    input wire logic [7:0] o_rd_data,
    input wire logic       o_rd_valid,
    input wire logic       o_alarm_n,
    input wire logic [7:0] o_drive_level,
    input wire logic       o_shutdown
);
    logic [7:0] ptr_q;
    longint     age_q;
    logic       clr;

    // Fault clear write through the current pointer
    assign clr = i_clk_en && i_data_wr && ptr_q == 8'h04 && i_wdata[7];

    // Pointer mirror; age counts cycles since reset or clear, so an early alarm shows
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ptr_q <= 8'h00;
            age_q <= 0;
        end else if (i_clk_en) begin
            if (i_cmd_wr) begin
                ptr_q <= i_cmd;
            end
            age_q <= clr ? 0 : age_q + 1;
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    // Read request through the pointer
    sequence read_of(logic [7:0] c);
        i_clk_en && i_rd_req && ptr_q == c;
    endsequence

    rd_valid_pulse_a: assert property (o_rd_valid == $past(i_clk_en && i_rd_req))
        else $error("read valid not one cycle after request");
    rd_data_hold_a: assert property (!o_rd_valid |-> $stable(o_rd_data))
        else $error("read data moved without a read");
    maker_read_a: assert property (read_of(8'h07) |=> o_rd_data == MAKER_VALUE)
        else $error("maker code wrong");
    revision_read_a: assert property (read_of(8'h08) |=> o_rd_data == {6'h00, VARIANT})
        else $error("revision code wrong");
    unmapped_read_a: assert property (i_clk_en && i_rd_req &&
        !(ptr_q inside {8'h00, 8'h02, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08}) |=> o_rd_data == 8'h00)
        else $error("unmapped read not zero");
    cfg_fixed_bits_a: assert property (read_of(8'h04) |=> o_rd_data[7] == 1'b0 && o_rd_data[4:3] == 2'b01)
        else $error("config fixed bits wrong");
    status_unused_a: assert property (read_of(8'h05) |=> (o_rd_data & 8'hd2) == 8'h00)
        else $error("status unused bits set");
    clear_release_a: assert property (clr |=> o_alarm_n)
        else $error("alarm not released by clear");
    alarm_hold_a: assert property (!o_alarm_n && !clr |=> !o_alarm_n)
        else $error("alarm dropped without clear");
    alarm_delay_a: assert property ($fell(o_alarm_n) |-> age_q >= FAULT_CYCLES - 2)
        else $error("alarm before persistence time");
    shutdown_drive_a: assert property (o_shutdown [*2] |-> o_drive_level == 8'h00)
        else $error("drive active in shutdown");
endmodule // fan_regs_checker

bind fan_controller_register_set fan_regs_checker #(
    .FAULT_CYCLES(FAULT_CYCLES), .MAKER_VALUE(MAKER_VALUE), .VARIANT(VARIANT)
) u_fan_regs_checker (
    .i_core_clk, .i_sys_rst, .i_clk_en, .i_cmd_wr, .i_cmd, .i_data_wr, .i_wdata, .i_rd_req,
    .i_tach_pin, .i_overtemp_pin, .i_input_open_pin, .i_analog_duty,
    .o_rd_data, .o_rd_valid, .o_alarm_n, .o_drive_level, .o_shutdown
);

// ---- fan_host_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Management host: command byte, then data or read
// ----------------------------------------------------------------
module fan_host_model (
    input  wire logic       i_core_clk,
    input  wire logic [7:0] i_rd_data,
    input  wire logic       i_rd_valid,
    output logic            o_cmd_wr,
    output logic      [7:0] o_cmd,
    output logic            o_data_wr,
    output logic      [7:0] o_wdata,
    output logic            o_rd_req
);
    initial begin
        o_cmd_wr  = 1'b0;
        o_cmd     = 8'h00;
        o_data_wr = 1'b0;
        o_wdata   = 8'h00;
        o_rd_req  = 1'b0;
    end

    // Released byte lanes carry the inverse, so stale values never look valid
    task automatic put_cmd(input logic [7:0] c);
        @(posedge i_core_clk);
        o_cmd_wr <= 1'b1;
        o_cmd    <= c;
        @(posedge i_core_clk);
        o_cmd_wr <= 1'b0;
        o_cmd    <= ~c;
    endtask

    task automatic write_reg(input logic [7:0] c, input logic [7:0] d);
        put_cmd(c);
        o_data_wr <= 1'b1;
        o_wdata   <= d;
        @(posedge i_core_clk);
        o_data_wr <= 1'b0;
        o_wdata   <= ~d;
    endtask

    task automatic read_reg(input logic [7:0] c, output logic [7:0] d, output logic ok);
        put_cmd(c);
        o_rd_req <= 1'b1;
        @(posedge i_core_clk);
        o_rd_req <= 1'b0;
        @(posedge i_core_clk);
        ok = i_rd_valid;
        d  = i_rd_data;
    endtask
endmodule // fan_host_model

// ---- fan_controller_register_set_tb.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Register set bench
// ----------------------------------------------------------------
module fan_controller_register_set_tb
    import fan_regs_pkg::*;
;
    localparam longint MEAS = 2100;
    localparam int     WIN  = 4220;
    logic i_core_clk, i_sys_rst, i_clk_en, i_cmd_wr, i_data_wr, i_rd_req, i_tach_pin;
    logic i_overtemp_pin, i_input_open_pin, o_rd_valid, o_alarm_n, o_shutdown, tach_on;
    logic [7:0] i_cmd, i_wdata, i_analog_duty, o_rd_data, o_drive_level;
    logic [1:0] tph = 2'b00;
    int n_errors = 0, n_compared = 0, cyc = 0;
    // Mode table: ppr 1, 2, 4, 8, each coarse then fine; 525 tach edges a window
    logic [7:0] cfg [8] = '{8'h08, 8'h48, 8'h0a, 8'h4a, 8'h0c, 8'h4c, 8'h0e, 8'h4e};
    logic [7:0] spd [8] = '{8'hff, 8'hff, 8'h83, 8'hff, 8'h41, 8'h83, 8'h20, 8'h41};
    logic [7:0] sts [8] = '{8'h08, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    fan_controller_register_set #(.MEAS_CYCLES(MEAS), .FAULT_CYCLES(100),
        .MAKER_VALUE(8'h3c), .VARIANT(2'b01)) u_fan_controller_register_set ( // Arbitrary ids
        .i_core_clk, .i_sys_rst, .i_clk_en, .i_cmd_wr, .i_cmd, .i_data_wr, .i_wdata, .i_rd_req,
        .i_tach_pin, .i_overtemp_pin, .i_input_open_pin, .i_analog_duty,
        .o_rd_data, .o_rd_valid, .o_alarm_n, .o_drive_level, .o_shutdown);
    fan_host_model u_fan_host_model (.i_core_clk, .i_rd_data(o_rd_data), .i_rd_valid(o_rd_valid),
        .o_cmd_wr(i_cmd_wr), .o_cmd(i_cmd), .o_data_wr(i_data_wr), .o_wdata(i_wdata),
        .o_rd_req(i_rd_req));

    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end

    // Tach period of four cycles; timeout guard
    always @(posedge i_core_clk) begin
        tph        <= tph + 2'd1;
        i_tach_pin <= tach_on & tph[1];
        cyc++;
        if (cyc == 60000) begin
            n_errors++;
            wrap_up();
        end
    end

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_read(input string what, input logic [7:0] c, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        u_fan_host_model.read_reg(c, d, ok);
        chk8({what, " valid"}, 8'h01, {7'h00, ok});
        chk8(what, exp, d);
    endtask

    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        u_fan_host_model.write_reg(c, d);
    endtask

    task automatic wrap_up;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        {i_sys_rst, i_clk_en, i_overtemp_pin, i_input_open_pin, tach_on} = 5'b11000;
        i_analog_duty = 8'h5c;
        repeat (2) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        // Reset values, read before the fault timer can run out
        chk8("alarm", 8'h01, {7'h00, o_alarm_n});
        chk_read("speed", 8'h00, 8'h00);
        chk_read("threshold", 8'h02, 8'h0a);
        chk_read("config", 8'h04, 8'h0a);
        chk_read("status", 8'h05, 8'h00);
        chk_read("drive", 8'h06, 8'h02);
        chk8("drive out", 8'h5c, o_drive_level);
        // Zero speed under default threshold, then clear
        repeat (100) @(posedge i_core_clk);
        chk8("alarm", 8'h00, {7'h00, o_alarm_n});
        chk_read("status", 8'h05, 8'h01);
        wr(8'h02, 8'h00);
        wr(8'h04, 8'h8a);
        @(posedge i_core_clk);
        chk8("alarm", 8'h01, {7'h00, o_alarm_n});
        chk_read("config", 8'h04, 8'h0a);
        // Read-only and unmapped places, live status pins, threshold top
        i_overtemp_pin   <= 1'b1;
        i_input_open_pin <= 1'b1;
        wr(8'h00, 8'hff);
        wr(8'h07, 8'h00);
        wr(8'h08, 8'hff);
        wr(8'h05, 8'hff);
        chk_read("speed", 8'h00, 8'h00);
        chk_read("maker", 8'h07, 8'h3c);
        chk_read("revision", 8'h08, 8'h01);
        chk_read("unmapped", 8'h03, 8'h00);
        chk_read("status", 8'h05, 8'h24);
        wr(8'h02, 8'hff);
        chk_read("threshold", 8'h02, 8'hff);
        wr(8'h02, 8'h00);
        i_overtemp_pin   <= 1'b0;
        i_input_open_pin <= 1'b0;
        // Drive source, drive register, shutdown
        wr(8'h04, 8'h30);
        chk_read("config", 8'h04, 8'h28);
        chk8("drive out", 8'h02, o_drive_level);
        wr(8'h06, 8'h77);
        repeat (2) @(posedge i_core_clk);
        chk8("drive out", 8'h77, o_drive_level);
        // Clock enable low: a whole write is lost
        i_clk_en <= 1'b0;
        wr(8'h06, 8'h11);
        i_clk_en <= 1'b1;
        chk_read("drive frozen", 8'h06, 8'h77);
        wr(8'h04, 8'h21);
        repeat (2) @(posedge i_core_clk);
        chk8("shutdown", 8'h01, {7'h00, o_shutdown});
        chk8("drive out", 8'h00, o_drive_level);
        i_analog_duty <= 8'ha3;
        wr(8'h04, 8'h0a);
        repeat (2) @(posedge i_core_clk);
        chk8("drive out", 8'ha3, o_drive_level);
        // Speed over every ppr code and both resolutions
        tach_on <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            wr(8'h04, cfg[k]);
            repeat (WIN) @(posedge i_core_clk);
            chk_read("speed", 8'h00, spd[k]);
            chk_read("status", 8'h05, sts[k]);
        end
        // Reading 65 units against thresholds 64 and 66
        wr(8'h02, 8'h20);
        repeat (150) @(posedge i_core_clk);
        chk8("alarm", 8'h01, {7'h00, o_alarm_n});
        wr(8'h02, 8'h21);
        repeat (150) @(posedge i_core_clk);
        chk8("alarm", 8'h00, {7'h00, o_alarm_n});
        chk_read("status", 8'h05, 8'h01);
        // Clear while the fan is still slow; the fault must come back later
        wr(8'h04, 8'hce);
        @(posedge i_core_clk);
        chk8("alarm", 8'h01, {7'h00, o_alarm_n});
        repeat (110) @(posedge i_core_clk);
        chk8("alarm", 8'h00, {7'h00, o_alarm_n});
        wr(8'h02, 8'h00);
        wr(8'h04, 8'hce);
        @(posedge i_core_clk);
        chk8("alarm", 8'h01, {7'h00, o_alarm_n});
        wrap_up();
    end
endmodule // fan_controller_register_set_tb
